// file: core/fbrc_defines.svh
`ifndef FBRC_DEFINES_SVH
`define FBRC_DEFINES_SVH
`define FBRC_ADDR_W      12
`define FBRC_DATA_W      32
`define FBRC_BLK_W       2
`define FBRC_PAGE_W      3
`define FBRC_SECT_W      2
`define FBRC_WORDS       128
`define FBRC_ST_OK       2'h0
`define FBRC_ST_NOERASE  2'h1
`define FBRC_ST_ECC      2'h2
`define FBRC_ST_WCOUNT   2'h3
`define FBRC_WTHRESH     8'hFE
`define FBRC_ERASE_CYC   4'h4
`define FBRC_FETCH_CYC   4'h8
`endif

// file: core/fbrc_device.sv
`timescale 1ns/10ps
`include "fbrc_defines.svh"
// Operation
// R1: Erase starts on page erase request
// R2: Erase clears chosen page to zeros
// R3: Protect inputs act as in program
// R4: Overwrite protected page refused, status 01
// R5: Loss protect: other page fails 01
// R6: Write count over threshold gives 11
// R7: Uncorrectable ECC error gives 10
// R8: Read from array, buffers or status
// R9: Normal or read-ahead via select input
// R10: Pipe setting adds one cycle latency
// R11: Background fetch of next block
// R12: Fetch address from fixed sequence
// R13: Next block; last block to next page
// R14: Spare page to next sector, wrap
// R15: Auxiliary block to next page's auxiliary
// R16: Mismatch waits pending fetch, max nine
// R17: Clean erase reports status 00
module fbrc_device
  import fbrc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  fbrc_if.dev                    bus,
  input  wire logic              ecc_fail_i,
  input  wire logic [`FBRC_PAGE_W-1:0] prot_page_i,
  input  wire logic              prot_en_i,
  output logic [7:0]             wcount_o
);
  localparam int AW = `FBRC_ADDR_W;
  // Address: spare flag, sector, aux flag, page, block, word
  typedef struct packed
  {
    fbrc_state_t                 st;
    logic [3:0]                  cnt;
    logic [AW-1:0]               ahead;
    logic                        ahead_ok;
    // Erase result waits here until done, so status stands meanwhile
    logic [1:0]                  pend;
    logic [`FBRC_DATA_W-1:0]     rdata;
    logic [1:0]                  status;
    logic                        done;
    logic [`FBRC_PAGE_W-1:0]     buf_page;
    logic [7:0]                  wcount;
  } fbrc_dev_t;
  fbrc_dev_t s_q, s_d;
  logic [`FBRC_DATA_W-1:0] mem_q [`FBRC_WORDS];
  logic [AW-1:0] a;
  logic [AW-1:0] nxt;
  logic [1:0] blk;
  logic       last_sect;
  logic       hit;
  logic       we;
  logic [6:0] widx;
  assign a = bus.addr;
  assign blk = a[3:2];
  assign last_sect = &a[10:9];
  assign widx = {a[6:4], a[3:2], a[1:0]};
  // Hit only when the block equals the fixed look-ahead address
  assign hit = s_q.ahead_ok && s_q.ahead[AW-1:2] == a[AW-1:2]; // R12
  // Look-ahead follows a fixed sequence, never the next request
  always_comb
  begin
    nxt = a;
    nxt[1:0] = 2'h0;
    if (a[11])
    begin
      // Spare pages step through sectors; the last wraps to sector 0
      nxt[10:9] = last_sect ? 2'h0 : a[10:9] + 2'h1; // R14
      nxt[6:2]  = 5'h0;
    end
    else if (a[7])
      nxt[6:4] = a[6:4] + 3'h1; // R15
    else if (blk != 2'h3)
      nxt[3:2] = blk + 2'h1; // R13
    else
    begin
      nxt[3:2] = 2'h0;
      {nxt[10:9], nxt[6:4]} = {a[10:9], a[6:4]} + 5'h1; // R13
    end
  end
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      FBRC_IDLE:
      begin
        if (bus.page_erase_request) // R1
        begin
          s_d.cnt = `FBRC_ERASE_CYC;
          // Checks run at the request; the code shows with done
          if (bus.page_overwrite_protect && prot_en_i &&
              prot_page_i == a[6:4])
            s_d.pend = `FBRC_ST_NOERASE; // R3 R4
          else if (bus.buffer_loss_protect && s_q.buf_page != a[6:4])
            s_d.pend = `FBRC_ST_NOERASE; // R3 R5
          else if (ecc_fail_i)
            s_d.pend = `FBRC_ST_ECC; // R7
          else if (s_q.wcount > `FBRC_WTHRESH)
            s_d.pend = `FBRC_ST_WCOUNT; // R6
          else
            s_d.pend = `FBRC_ST_OK; // R17
          s_d.st = FBRC_ERASE;
        end
        else if (bus.read_req)
        begin
          // Page and status sources skip the fetch engine; array and block reads skip it on a hit
          if (bus.src != FBRC_SRC_ARRAY && bus.src != FBRC_SRC_BLOCK)
          begin
            s_d.st = bus.pipe ? FBRC_PIPE : FBRC_DONE; // R10
          end
          else if (hit) // R12
          begin
            s_d.st = bus.pipe ? FBRC_PIPE : FBRC_DONE; // R10
          end
          else
          begin
            // Mismatch waits fetch; busy lasts nine cycles, ten with pipe
            s_d.cnt = `FBRC_FETCH_CYC; // R16
            s_d.st = FBRC_FETCH;
          end
          if (bus.read_ahead_select) // R9
          begin
            s_d.ahead = nxt; // R11 R12
            s_d.ahead_ok = 1'b1;
          end
          else
            s_d.ahead_ok = 1'b0;
        end
      end
      FBRC_ERASE:
      begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1)
        begin
          s_d.done = 1'b1;
          s_d.status = s_q.pend; // R4 R17
          // Refused erases leave the single shared wear count alone
          if (s_q.pend != `FBRC_ST_NOERASE)
            s_d.wcount = s_q.wcount + 8'h1;
          s_d.st = FBRC_IDLE;
        end
      end
      FBRC_FETCH:
      begin
        s_d.cnt = s_q.cnt - 4'h1;
        // Data is picked up in the done state, not here
        if (s_q.cnt == 4'h1)
        begin
          s_d.st = bus.pipe ? FBRC_PIPE : FBRC_DONE; // R10
        end
      end
      FBRC_PIPE:
        s_d.st = FBRC_DONE;
      FBRC_DONE:
      begin
        // Data changes only with done, so it stands meanwhile
        if (bus.src == FBRC_SRC_STATUS)
          s_d.rdata = {30'h0, s_q.status}; // R8
        else
          s_d.rdata = mem_q[widx]; // R8
        s_d.done = 1'b1;
        s_d.st = FBRC_IDLE;
      end
      default:
        s_d.st = FBRC_IDLE;
    endcase
  end
  // Only code 01 leaves the page untouched
  assign we = s_q.st == FBRC_ERASE && s_q.cnt == 4'h1 &&
              s_q.pend != `FBRC_ST_NOERASE;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Erase clears the page's 16 words
  // Reset loads each word with its own index as a test pattern
  genvar g;
  for (g = 0; g < `FBRC_WORDS; g++)
  begin : g_mem
    localparam logic [2:0] PG = 3'(g >> 4);
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        mem_q[g] <= 32'(g);
      else if (we && PG == a[6:4])
        mem_q[g] <= '0; // R2
    end
  end
  // Done only follows the return to idle, so busy is low with it
  assign bus.busy   = s_q.st != FBRC_IDLE;
  assign bus.done   = s_q.done;
  assign bus.status = s_q.status;
  assign bus.rdata  = s_q.rdata;
  assign wcount_o   = s_q.wcount;
endmodule

// file: core/fbrc_if.sv
`timescale 1ns/10ps
`include "fbrc_defines.svh"
interface fbrc_if;
  import fbrc_pkg::*;
  logic                      page_erase_request;
  logic                      page_overwrite_protect;
  logic                      buffer_loss_protect;
  logic                      read_req;
  logic                      read_ahead_select;
  logic                      pipe;
  fbrc_src_t                 src;
  logic [`FBRC_ADDR_W-1:0]   addr;
  logic                      busy;
  logic                      done;
  logic [1:0]                status;
  logic [`FBRC_DATA_W-1:0]   rdata;
  modport dev
  (
    input  page_erase_request, page_overwrite_protect, buffer_loss_protect,
    input  read_req, read_ahead_select, pipe, src, addr,
    output busy, done, status, rdata
  );
  modport usr
  (
    output page_erase_request, page_overwrite_protect, buffer_loss_protect,
    output read_req, read_ahead_select, pipe, src, addr,
    input  busy, done, status, rdata
  );
endinterface

// file: core/fbrc_pkg.sv
`include "fbrc_defines.svh"
package fbrc_pkg;
  typedef enum logic [1:0]
  {
    FBRC_SRC_ARRAY  = 2'h0,
    FBRC_SRC_PAGE   = 2'h1,
    FBRC_SRC_BLOCK  = 2'h2,
    FBRC_SRC_STATUS = 2'h3
  } fbrc_src_t;
  typedef enum logic [2:0]
  {
    FBRC_IDLE  = 3'h0,
    FBRC_ERASE = 3'h1,
    FBRC_FETCH = 3'h2,
    FBRC_PIPE  = 3'h3,
    FBRC_DONE  = 3'h4
  } fbrc_state_t;
endpackage

// file: core/fbrc_user.sv
`timescale 1ns/10ps
`include "fbrc_defines.svh"
module fbrc_user
  import fbrc_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  fbrc_if.usr                          bus,
  input  wire logic                    erase_i,
  input  wire logic                    read_i,
  input  wire logic                    ahead_i,
  input  wire logic                    pipe_i,
  input  wire logic                    ovw_i,
  input  wire logic                    loss_i,
  input  wire fbrc_src_t               src_i,
  input  wire logic [`FBRC_ADDR_W-1:0] addr_i,
  output logic                         ack_o,
  output logic [1:0]                   status_o,
  output logic [`FBRC_DATA_W-1:0]      data_o
);
  typedef struct packed
  {
    logic                      wait_r;
    logic                      erase;
    logic                      read;
    logic                      ahead;
    logic                      pipe;
    logic                      ovw;
    logic                      loss;
    fbrc_src_t                 src;
    logic [`FBRC_ADDR_W-1:0]   addr;
    logic                      ack;
    logic [1:0]                status;
    logic [`FBRC_DATA_W-1:0]   data;
  } fbrc_usr_t;
  fbrc_usr_t u_q, u_d;
  always_comb
  begin
    u_d = u_q;
    u_d.erase = 1'b0;
    u_d.read = 1'b0;
    u_d.ack = 1'b0;
    if (!u_q.wait_r && (erase_i || read_i))
    begin
      u_d.erase = erase_i; // R1
      u_d.read = !erase_i && read_i;
      u_d.ahead = ahead_i; // R9
      u_d.pipe = pipe_i; // R10
      u_d.ovw = ovw_i; // R3
      u_d.loss = loss_i; // R3
      u_d.src = src_i;
      u_d.addr = addr_i;
      u_d.wait_r = 1'b1;
    end
    else if (u_q.wait_r && bus.done) // R16
    begin
      u_d.wait_r = 1'b0;
      u_d.ack = 1'b1;
      u_d.status = bus.status;
      u_d.data = bus.rdata;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      u_q <= '0;
    else
      u_q <= u_d;
  end
  assign bus.page_erase_request     = u_q.erase;
  assign bus.read_req               = u_q.read;
  assign bus.read_ahead_select      = u_q.ahead;
  assign bus.pipe                   = u_q.pipe;
  assign bus.page_overwrite_protect = u_q.ovw;
  assign bus.buffer_loss_protect    = u_q.loss;
  assign bus.src                    = u_q.src;
  assign bus.addr                   = u_q.addr;
  assign ack_o                      = u_q.ack;
  assign status_o                   = u_q.status;
  assign data_o                     = u_q.data;
endmodule

// file: verif/fbrc_chk.sv
`timescale 1ns/10ps
`include "fbrc_defines.svh"
module fbrc_chk
  import fbrc_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    page_erase_request,
  input wire logic                    read_req,
  input wire logic                    pipe,
  input wire fbrc_src_t               src,
  input wire logic                    busy,
  input wire logic                    done,
  input wire logic [1:0]              status,
  input wire logic [`FBRC_DATA_W-1:0] rdata
);
  // Saturates so a stuck busy cannot wrap back to a legal count
  logic [3:0] bcnt_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !busy)
      bcnt_q <= 4'h0;
    else if (bcnt_q != 4'hF)
      bcnt_q <= bcnt_q + 4'h1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_erase_done_time: assert property
    ($rose(page_erase_request) |-> ##5 done)
    else $error("erase done not five cycles after request");
  a_erase_busy_run: assert property
    ($rose(page_erase_request) |-> ##1 busy[*4])
    else $error("busy dropped during erase");
  a_read_plain_lat: assert property ($rose(read_req) && !pipe &&
    (src == FBRC_SRC_PAGE || src == FBRC_SRC_STATUS) |-> ##2 done)
    else $error("plain read latency wrong");
  a_read_pipe_lat: assert property ($rose(read_req) && pipe &&
    (src == FBRC_SRC_PAGE || src == FBRC_SRC_STATUS) |-> ##3 done)
    else $error("pipelined read latency wrong");
  a_read_done_bound: assert property
    ($rose(read_req) |-> ##[1:11] done)
    else $error("read never completed");
  a_busy_run_bound: assert property (bcnt_q <= 4'hA)
    else $error("busy held too long");
  a_status_stands: assert property (!done |-> $stable(status))
    else $error("status changed without completion");
  a_rdata_stands: assert property (!done |-> $stable(rdata))
    else $error("read data changed without completion");
  a_done_not_busy: assert property (done |-> !busy)
    else $error("done while busy");
  cover property ($rose(page_erase_request) ##5 done);
  cover property (done && status == 2'h1);
  cover property (done && status == 2'h2);
  cover property (done && status == 2'h3);
endmodule

// file: verif/testbench.sv
`timescale 1ns/10ps
`include "fbrc_defines.svh"
module testbench
  import fbrc_pkg::*;
;
  logic                     clk_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic                     erase_i = 1'b0;
  logic                     read_i = 1'b0;
  logic                     ahead_i = 1'b0;
  logic                     pipe_i = 1'b0;
  logic                     ovw_i = 1'b0;
  logic                     loss_i = 1'b0;
  logic                     ecc_fail_i = 1'b0;
  logic                     prot_en_i = 1'b0;
  logic [2:0]               prot_page_i = 3'h3;
  fbrc_src_t                src_i = FBRC_SRC_ARRAY;
  logic [11:0]              addr_i = 12'h000;
  logic                     ack_o;
  logic [1:0]               status_o;
  logic [31:0]              data_o;
  logic [7:0]               wcount_o;
  int                       err_count = 0;
  int                       checks_done = 0;
  int                       cyc = 0;
  fbrc_if bus_if ();
  fbrc_device fbrc_device_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.dev),
    .ecc_fail_i(ecc_fail_i), .prot_page_i(prot_page_i),
    .prot_en_i(prot_en_i), .wcount_o(wcount_o));
  fbrc_user fbrc_user_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.usr),
    .erase_i(erase_i), .read_i(read_i), .ahead_i(ahead_i), .pipe_i(pipe_i),
    .ovw_i(ovw_i), .loss_i(loss_i), .src_i(src_i), .addr_i(addr_i),
    .ack_o(ack_o), .status_o(status_o), .data_o(data_o));
  fbrc_chk fbrc_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .page_erase_request(bus_if.page_erase_request),
    .read_req(bus_if.read_req), .pipe(bus_if.pipe), .src(bus_if.src),
    .busy(bus_if.busy), .done(bus_if.done), .status(bus_if.status),
    .rdata(bus_if.rdata));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Ceiling well above the wear test's roughly 2000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic op(input logic er, input fbrc_src_t s, input logic [11:0] a,
                    input logic pp, input logic ah);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    erase_i = er;
    read_i = !er;
    src_i = s;
    addr_i = a;
    pipe_i = pp;
    ahead_i = ah;
    @(posedge clk_i);
    #1;
    erase_i = 1'b0;
    read_i = 1'b0;
    while (ack_o !== 1'b1 && n < 40)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("ack", {31'h0, ack_o}, 32'h1);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    op(1'b0, FBRC_SRC_ARRAY, 12'h027, 1'b0, 1'b0);
    chk("array word", data_o, 32'h27);
    op(1'b0, FBRC_SRC_ARRAY, 12'h051, 1'b1, 1'b0);
    chk("pipe word", data_o, 32'h51);
    $display("array reads done");
    op(1'b1, FBRC_SRC_ARRAY, 12'h027, 1'b0, 1'b0);
    chk("clean status", {30'h0, status_o}, 32'h0);
    chk("erase count", {24'h0, wcount_o}, 32'h1);
    op(1'b0, FBRC_SRC_ARRAY, 12'h027, 1'b0, 1'b0);
    chk("erased word", data_o, 32'h0);
    $display("clean erase done");
    prot_en_i = 1'b1;
    ovw_i = 1'b1;
    op(1'b1, FBRC_SRC_ARRAY, 12'h030, 1'b0, 1'b0);
    chk("protect status", {30'h0, status_o}, 32'h1);
    prot_en_i = 1'b0;
    ovw_i = 1'b0;
    op(1'b0, FBRC_SRC_ARRAY, 12'h030, 1'b0, 1'b0);
    chk("kept word", data_o, 32'h30);
    loss_i = 1'b1;
    op(1'b1, FBRC_SRC_ARRAY, 12'h050, 1'b0, 1'b0);
    chk("loss status", {30'h0, status_o}, 32'h1);
    loss_i = 1'b0;
    ecc_fail_i = 1'b1;
    op(1'b1, FBRC_SRC_ARRAY, 12'h060, 1'b0, 1'b0);
    chk("ecc status", {30'h0, status_o}, 32'h2);
    ecc_fail_i = 1'b0;
    $display("erase errors done");
    op(1'b0, FBRC_SRC_BLOCK, 12'h004, 1'b0, 1'b1);
    chk("ahead first", data_o, 32'h4);
    op(1'b0, FBRC_SRC_BLOCK, 12'h008, 1'b0, 1'b1);
    chk("ahead next", data_o, 32'h8);
    op(1'b0, FBRC_SRC_BLOCK, 12'h044, 1'b1, 1'b1);
    chk("ahead miss", data_o, 32'h44);
    // Status source returns the last erase code, here the ECC one
    for (int i = 0; i < 4; i++)
    begin
      op(1'b0, i[1] ? FBRC_SRC_STATUS : FBRC_SRC_PAGE, 12'h011, i[0], 1'b0);
      chk("source word", data_o, i[1] ? 32'h2 : 32'h11);
    end
    $display("reads done");
    repeat (253)
      op(1'b1, FBRC_SRC_ARRAY, 12'h070, 1'b0, 1'b0);
    chk("worn count", {24'h0, wcount_o}, 32'hFF);
    op(1'b1, FBRC_SRC_ARRAY, 12'h070, 1'b0, 1'b0);
    chk("worn status", {30'h0, status_o}, 32'h3);
    $display("wear test done");
    final_report();
  end
endmodule
